/* File: include/rpd_consts.vh */
// Constants shared by the remote process data channel bank and its descriptor table.
// Assumes a 100 MHz clock and an AXI4-Lite master with 12 address bits.
`ifndef RPD_CONSTS_VH
`define RPD_CONSTS_VH

`define CLK_PERIOD_NS       10
`define XCHG_TIMEOUT_NS     100000

`define OFS_COMMAND         12'h000
`define OFS_DATA            12'h004
`define OFS_INFO            12'h008
`define OFS_DESC_ADDR       12'h00c
`define OFS_DESC_DATA       12'h010
`define OFS_CHAN_PAGE       4'h1

`define CMD_OP_STOP         8'h08
`define CMD_OP_START        8'h09
`define CMD_OP_SETUP        8'h0f
`define CMD_OP_XCHG         8'h10

`define CS_RFLT_LSB         24
`define CS_MODE_LSB         24
`define CS_COMM_ERR_BIT     13
`define CS_NO_REMOTE_BIT    14
`define FW_VERSION_DEF      8'h1d
`define FW_RFLT_MIN_VER     8'h1c

`define RFLT_LINK_BIT       7
`define RFLT_KEEPALIVE_BIT  0

`define RST_WORD            32'h00000000
`define RST_BYTE            8'h00
`define RESP_OKAY           2'h0
`define RESP_SLVERR         2'h2

`define REC_ELEMENT         8'ha0
`define REC_SETTING         8'hb0
`define TYPE_PAD            8'h00
`define TYPE_BITS           8'h01
`define TYPE_BOOLEAN        8'h07
`define DIR_IN              8'h00
`define DIR_TWO_WAY         8'h40
`define DIR_OUT             8'h80
`define KIND_FIXED          8'h00
`define KIND_RUNTIME        8'h01
`define MAX_ELEM_BITS       8'h60
`define WIDE_BITS           8'h30
`define NARROW_BITS         8'h18
`define SCALE_LOW           32'h00000000
`define SCALE_HIGH          32'h3f800000

`define SWM_IN_OUT          8'h00
`define SWM_IN_ONLY         8'h01
`define SWM_OUT_ONLY        8'h02
`define SWM_SPLIT           8'h03

`define TOC_BASE            16'h0010
`define GTOC_BASE           16'h0000
`define PDD_IN_BASE         16'h0020
`define PDD_OUT_BASE        16'h0040
`define SET_HW_BASE         16'h0060
`define SET_SW_BASE         16'h0070
`define LOC_IN              16'h0000
`define LOC_OUT             16'h0006

`endif

/* File: logic/rpd_channel_bank.v */
// Eight-channel register bank of the remote process data link, reached over AXI4-Lite.
// Assumes a link engine on the same clock that serves one channel request at a time
// and a bit-order jumper arriving asynchronously on a pin.
`include "rpd_consts.vh"
`default_nettype none

module rpd_channel_bank #(
  parameter [31:0] UNIT_NUMBER      = 32'h00000001, // Arbitrary value.
  parameter [31:0] DEVICE_NAME      = 32'h31444e4b, // Arbitrary value.
  parameter [7:0]  FW_VERSION       = `FW_VERSION_DEF,
  parameter        DISCOVERY_EN     = 1,
  parameter [19:0] XCHG_TIMEOUT_CYC = `XCHG_TIMEOUT_NS / `CLK_PERIOD_NS
) (
  input  wire        aclk,            // Clock
  input  wire        aresetn,         // Synchronous reset, active low
  input  wire [11:0] s_axi_awaddr,    // Write address
  input  wire        s_axi_awvalid,   // Write address valid
  output reg         s_axi_awready,   // Write address ready
  input  wire [31:0] s_axi_wdata,     // Write data
  input  wire [3:0]  s_axi_wstrb,     // Write byte strobes
  input  wire        s_axi_wvalid,    // Write data valid
  output reg         s_axi_wready,    // Write data ready
  output reg  [1:0]  s_axi_bresp,     // Write response
  output reg         s_axi_bvalid,    // Write response valid
  input  wire        s_axi_bready,    // Write response ready
  input  wire [11:0] s_axi_araddr,    // Read address
  input  wire        s_axi_arvalid,   // Read address valid
  output reg         s_axi_arready,   // Read address ready
  output reg  [31:0] s_axi_rdata,     // Read data
  output reg  [1:0]  s_axi_rresp,     // Read response
  output reg         s_axi_rvalid,    // Read data valid
  input  wire        s_axi_rready,    // Read data ready
  input  wire        bit_order_pin,   // Bit-order jumper, asynchronous
  input  wire [7:0]  lnk_present,     // Remote device answers on channel
  input  wire        lnk_done,        // Requested transfer finished, pulse
  input  wire        lnk_fail,        // Finished transfer had an error
  input  wire [31:0] lnk_in0,         // Inbound payload bytes 0 to 3
  input  wire [31:0] lnk_in1,         // Inbound payload bytes 4 to 7
  input  wire [31:0] lnk_in2,         // Inbound payload bytes 8 to 11
  input  wire [23:0] lnk_status,      // State, status and local faults
  input  wire [7:0]  lnk_rflt,        // Remote fault byte
  output reg         lnk_req_q,       // Transfer request, pulse
  output reg  [2:0]  lnk_chan_q,      // Channel of the request
  output reg  [31:0] lnk_out0_q,      // Outbound payload bytes 0 to 3
  output reg  [31:0] lnk_out1_q,      // Outbound payload bytes 4 to 7
  output reg  [31:0] lnk_out2_q,      // Outbound payload bytes 8 to 11
  output reg  [7:0]  lnk_mode_q,      // Runtime setting of the channel
  output reg         lnk_hw_order_q   // Captured bit-order setting
);

  localparam [2:0] ST_IDLE = 3'b001;
  localparam [2:0] ST_SCAN = 3'b010;
  localparam [2:0] ST_WAIT = 3'b100;

  localparam [2:0] K_CMD  = 3'd0;
  localparam [2:0] K_DATA = 3'd1;
  localparam [2:0] K_INFO = 3'd2;
  localparam [2:0] K_DADR = 3'd3;
  localparam [2:0] K_DDAT = 3'd4;
  localparam [2:0] K_CHAN = 3'd5;
  localparam [2:0] K_NONE = 3'd7;

  reg [31:0] in_w  [0:31];
  reg [31:0] out_w [0:31];
  reg [7:0]  mode_q [0:7];
  reg [7:0]  started_q;
  reg [15:0] cmd_q;
  reg [31:0] data_q;
  reg [7:0]  pend_q;
  reg [7:0]  fail_q;
  reg [2:0]  ch_q;
  reg [19:0] tmr_q;
  reg [2:0]  st_q;
  reg [15:0] desc_addr_q;
  reg [2:0]  desc_ch_q;
  reg        strap_m_q;
  reg        strap_s_q;
  reg        cap_done_q;
  reg        aw_hold_q;
  reg        w_hold_q;
  reg [11:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0]  wstrb_q;
  reg [31:0] rd_word;
  reg [2:0]  pick;
  wire       wr_go;
  wire [7:0] rom_byte;
  integer    i;

  // Address classes; channel words sit at page 1, 16 bytes per channel.
  function [2:0] addr_kind;
    input [11:0] a;
    begin
      if (a[1:0] != 2'b00) begin
        addr_kind = K_NONE;
      end else if (a == `OFS_COMMAND) begin
        addr_kind = K_CMD;
      end else if (a == `OFS_DATA) begin
        addr_kind = K_DATA;
      end else if (a == `OFS_INFO) begin
        addr_kind = K_INFO;
      end else if (a == `OFS_DESC_ADDR) begin
        addr_kind = K_DADR;
      end else if (a == `OFS_DESC_DATA) begin
        addr_kind = K_DDAT;
      end else if (a[11:8] == `OFS_CHAN_PAGE && !a[7]) begin
        addr_kind = K_CHAN;
      end else begin
        addr_kind = K_NONE;
      end
    end
  endfunction

  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  strb;
    integer      b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          merge[b*8 +: 8] = nw[b*8 +: 8];
        end
      end
    end
  endfunction

  function [2:0] lowest;
    input [7:0] m;
    integer     k;
    begin
      lowest = 3'd0;
      for (k = 7; k >= 0; k = k - 1) begin
        if (m[k]) begin
          lowest = k[2:0];
        end
      end
    end
  endfunction

  assign wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;

  rpd_desc_rom u_rom (
    .addr     (desc_addr_q),
    .sw_mode  (mode_q[desc_ch_q]),
    .hw_order (lnk_hw_order_q),
    .rd_byte  (rom_byte)
  );

  // Caught once after release; the synchroniser runs through reset so it is valid by then.
  always @(posedge aclk) begin
    strap_m_q <= bit_order_pin;
    strap_s_q <= strap_m_q;
    if (!aresetn) begin
      cap_done_q     <= 1'b0;
      lnk_hw_order_q <= 1'b0;
    end else begin
      cap_done_q <= 1'b1;
      if (cap_done_q == 1'b0) begin
        lnk_hw_order_q <= strap_s_q;
      end
    end
  end

  // Address and data are taken in either order and held until the response is taken.
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      awaddr_q      <= 12'h000;
      wdata_q       <= `RST_WORD;
      wstrb_q       <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q     <= 1'b1;
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q     <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (addr_kind(awaddr_q) == K_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Reads return the inbound side; outbound words are write-only by design.
  always @* begin
    case (addr_kind(s_axi_araddr))
      K_CMD:   rd_word = {16'h0000, cmd_q};
      K_DATA:  rd_word = data_q;
      K_INFO:  rd_word = {23'h000000, lnk_hw_order_q, FW_VERSION};
      K_DADR:  rd_word = {13'h0000, desc_ch_q, desc_addr_q};
      K_DDAT:  rd_word = {24'h000000, rom_byte};
      K_CHAN:  rd_word = in_w[{s_axi_araddr[6:4], s_axi_araddr[3:2]}];
      default: rd_word = `RST_WORD;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= `RST_WORD;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_word;
        s_axi_rresp   <= (addr_kind(s_axi_araddr) == K_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  always @* begin
    pick = lowest(pend_q);
  end

  // Command engine and register storage. Bus writes come last so a stop is never lost.
  always @(posedge aclk) begin
    if (!aresetn) begin
      for (i = 0; i < 32; i = i + 1) begin
        in_w[i]  <= `RST_WORD;
        out_w[i] <= `RST_WORD;
      end
      for (i = 0; i < 8; i = i + 1) begin
        mode_q[i] <= `RST_BYTE;
      end
      started_q   <= 8'h00;
      cmd_q       <= 16'h0000;
      data_q      <= `RST_WORD;
      pend_q      <= 8'h00;
      fail_q      <= 8'h00;
      ch_q        <= 3'd0;
      tmr_q       <= 20'h00000;
      st_q        <= ST_IDLE;
      desc_addr_q <= 16'h0000;
      desc_ch_q   <= 3'd0;
      lnk_req_q   <= 1'b0;
      lnk_chan_q  <= 3'd0;
      lnk_out0_q  <= `RST_WORD;
      lnk_out1_q  <= `RST_WORD;
      lnk_out2_q  <= `RST_WORD;
      lnk_mode_q  <= `RST_BYTE;
    end else begin
      lnk_req_q <= 1'b0;
      case (st_q)
        ST_IDLE: begin
          if (cmd_q != 16'h0000) begin
            case (cmd_q[15:8])
              `CMD_OP_STOP: begin
                for (i = 0; i < 8; i = i + 1) begin
                  if (cmd_q[7:0] == 8'h00 || cmd_q[i]) begin
                    started_q[i] <= 1'b0;
                    in_w[i*4]    <= `RST_WORD;
                  end
                end
                cmd_q  <= 16'h0000;
                data_q <= `RST_WORD;
              end
              `CMD_OP_START, `CMD_OP_SETUP: begin
                for (i = 0; i < 8; i = i + 1) begin
                  if (cmd_q[i] && lnk_present[i]) begin
                    started_q[i] <= 1'b1;
                    mode_q[i]    <= out_w[i*4][`CS_MODE_LSB +: 8];
                    in_w[i*4]    <= {`RST_BYTE, lnk_status};
                    if (cmd_q[15:8] == `CMD_OP_START && FW_VERSION > `FW_RFLT_MIN_VER) begin
                      in_w[i*4] <= {lnk_rflt, lnk_status};
                    end
                    in_w[i*4+1] <= UNIT_NUMBER;
                    in_w[i*4+2] <= DEVICE_NAME;
                    // A device without discovery shows zero pointers.
                    in_w[i*4+3] <= DISCOVERY_EN ? {`GTOC_BASE, `TOC_BASE} : `RST_WORD;
                  end else if (cmd_q[i]) begin
                    in_w[i*4] <= `RST_WORD | (32'h00000001 << `CS_NO_REMOTE_BIT);
                  end
                end
                data_q <= {24'h000000, cmd_q[7:0] & ~lnk_present};
                cmd_q  <= 16'h0000;
              end
              `CMD_OP_XCHG: begin
                pend_q <= cmd_q[7:0];
                fail_q <= 8'h00;
                st_q   <= ST_SCAN;
              end
              default: begin
                data_q <= {24'h000000, cmd_q[7:0]};
                cmd_q  <= 16'h0000;
              end
            endcase
          end
        end
        ST_SCAN: begin
          if (cmd_q[15:8] == `CMD_OP_STOP) begin
            st_q <= ST_IDLE;
          end else if (pend_q == 8'h00) begin
            cmd_q  <= 16'h0000;
            data_q <= {24'h000000, fail_q};
            st_q   <= ST_IDLE;
          end else if (started_q[pick]) begin
            ch_q       <= pick;
            lnk_req_q  <= 1'b1;
            lnk_chan_q <= pick;
            lnk_out0_q <= out_w[{pick, 2'd1}];
            lnk_out1_q <= out_w[{pick, 2'd2}];
            lnk_out2_q <= out_w[{pick, 2'd3}];
            lnk_mode_q <= mode_q[pick];
            tmr_q      <= 20'h00000;
            st_q       <= ST_WAIT;
          end else begin
            // A channel that never started fails without touching the link.
            fail_q[pick] <= 1'b1;
            pend_q[pick] <= 1'b0;
          end
        end
        ST_WAIT: begin
          if (cmd_q[15:8] == `CMD_OP_STOP) begin
            st_q <= ST_IDLE;
          end else if (lnk_done) begin
            in_w[{ch_q, 2'd0}] <= {lnk_rflt, lnk_status};
            in_w[{ch_q, 2'd1}] <= lnk_in0;
            in_w[{ch_q, 2'd2}] <= lnk_in1;
            in_w[{ch_q, 2'd3}] <= lnk_in2;
            fail_q[ch_q] <= lnk_fail;
            pend_q[ch_q] <= 1'b0;
            st_q         <= ST_SCAN;
          end else if (tmr_q == XCHG_TIMEOUT_CYC - 20'h00001) begin
            // A timed-out transfer counts as finished so the command can complete.
            in_w[{ch_q, 2'd0}][`CS_COMM_ERR_BIT] <= 1'b1;
            fail_q[ch_q] <= 1'b1;
            pend_q[ch_q] <= 1'b0;
            st_q         <= ST_SCAN;
          end else begin
            tmr_q <= tmr_q + 20'h00001;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
      if (wr_go) begin
        case (addr_kind(awaddr_q))
          K_CMD: begin
            // While busy only a stop is accepted; other writes are dropped.
            if ((st_q == ST_IDLE && cmd_q == 16'h0000) || wdata_q[15:8] == `CMD_OP_STOP) begin
              cmd_q <= {wstrb_q[1] ? wdata_q[15:8] : cmd_q[15:8],
                        wstrb_q[0] ? wdata_q[7:0] : cmd_q[7:0]};
            end
          end
          K_DADR: begin
            if (wstrb_q[0]) begin
              desc_addr_q[7:0] <= wdata_q[7:0];
            end
            if (wstrb_q[1]) begin
              desc_addr_q[15:8] <= wdata_q[15:8];
            end
            if (wstrb_q[2]) begin
              desc_ch_q <= wdata_q[18:16];
            end
          end
          K_CHAN: begin
            out_w[{awaddr_q[6:4], awaddr_q[3:2]}] <=
              merge(out_w[{awaddr_q[6:4], awaddr_q[3:2]}], wdata_q, wstrb_q);
          end
          default: begin
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

/* File: logic/rpd_desc_rom.v */
// Self-describing tables of the remote I/O device: index table and descriptors.
// Assumes a registered byte address; the byte answer is combinational.
`include "rpd_consts.vh"
`default_nettype none

module rpd_desc_rom (
  input  wire [15:0] addr,      // Byte address into the descriptor space
  input  wire [7:0]  sw_mode,   // Runtime setting of the channel
  input  wire        hw_order,  // Jumper bit-order setting
  output reg  [7:0]  rd_byte    // Byte at addr
);

  reg [15:0] toc0;
  reg [15:0] toc1;
  reg [15:0] toc2;
  reg [15:0] toc3;
  reg [7:0]  width;
  reg [15:0] entry;
  reg [15:0] toc_off;

  localparam [31:0] LOW_WORD  = `SCALE_LOW;
  localparam [31:0] HIGH_WORD = `SCALE_HIGH;

  // Element descriptor byte at offset off.
  function [7:0] elem_byte;
    input [4:0]  off;
    input [7:0]  size;
    input [7:0]  dir;
    input [15:0] loc;
    input [23:0] name;
    begin
      case (off)
        5'd0:    elem_byte = `REC_ELEMENT;
        5'd1:    elem_byte = size;
        5'd2:    elem_byte = `TYPE_BITS;
        5'd3:    elem_byte = dir;
        5'd4:    elem_byte = LOW_WORD[7:0];
        5'd5:    elem_byte = LOW_WORD[15:8];
        5'd6:    elem_byte = LOW_WORD[23:16];
        5'd7:    elem_byte = LOW_WORD[31:24];
        5'd8:    elem_byte = HIGH_WORD[7:0];
        5'd9:    elem_byte = HIGH_WORD[15:8];
        5'd10:   elem_byte = HIGH_WORD[23:16];
        5'd11:   elem_byte = HIGH_WORD[31:24];
        5'd12:   elem_byte = loc[7:0];
        5'd13:   elem_byte = loc[15:8];
        5'd14:   elem_byte = 8'h62;
        5'd16:   elem_byte = name[23:16];
        5'd17:   elem_byte = name[15:8];
        5'd18:   elem_byte = name[7:0];
        default: elem_byte = 8'h00;
      endcase
    end
  endfunction

  // Setting descriptor byte at offset off.
  function [7:0] set_byte;
    input [3:0] off;
    input [7:0] idx;
    input [7:0] kind;
    input [7:0] letter;
    begin
      case (off)
        4'd0:    set_byte = `REC_SETTING;
        4'd1:    set_byte = idx;
        4'd2:    set_byte = kind;
        4'd4:    set_byte = letter;
        default: set_byte = 8'h00;
      endcase
    end
  endfunction

  always @* begin
    toc0  = `PDD_IN_BASE;
    toc1  = `PDD_OUT_BASE;
    toc2  = `SET_HW_BASE;
    toc3  = `SET_SW_BASE;
    width = (sw_mode == `SWM_SPLIT) ? `NARROW_BITS : `WIDE_BITS;
    if (sw_mode == `SWM_IN_ONLY) begin
      toc1 = `SET_HW_BASE;
      toc2 = `SET_SW_BASE;
      toc3 = 16'h0000;
    end else if (sw_mode == `SWM_OUT_ONLY) begin
      toc0 = `PDD_OUT_BASE;
      toc1 = `SET_HW_BASE;
      toc2 = `SET_SW_BASE;
      toc3 = 16'h0000;
    end
    toc_off = addr - `TOC_BASE;
    case (toc_off[15:1])
      15'd0:   entry = toc0;
      15'd1:   entry = toc1;
      15'd2:   entry = toc2;
      15'd3:   entry = toc3;
      default: entry = 16'h0000;
    endcase
    if (addr >= `TOC_BASE && addr < `PDD_IN_BASE) begin
      rd_byte = toc_off[0] ? entry[15:8] : entry[7:0];
    end else if (addr[15:5] == `PDD_IN_BASE >> 5) begin
      rd_byte = elem_byte(addr[4:0], width, `DIR_IN, `LOC_IN, 24'h696e00);
    end else if (addr[15:5] == `PDD_OUT_BASE >> 5) begin
      rd_byte = elem_byte(addr[4:0], width, `DIR_OUT, `LOC_OUT, 24'h6f7574);
    end else if (addr[15:4] == `SET_HW_BASE >> 4) begin
      rd_byte = set_byte(addr[3:0], {7'h00, hw_order}, `KIND_FIXED, 8'h68);
    end else if (addr[15:4] == `SET_SW_BASE >> 4) begin
      rd_byte = set_byte(addr[3:0], sw_mode, `KIND_RUNTIME, 8'h73);
    end else begin
      rd_byte = 8'h00;
    end
  end

endmodule

`default_nettype wire

/* File: testbench/rpd_channel_bank_assertions.sv */
// Checker on the channel bank ports, attached by bind.
// Assumes one clock with a synchronous active-low reset.
`default_nettype none
module rpd_chk (
  input wire logic        aclk,          // Clock
  input wire logic        aresetn,       // Reset
  input wire logic        s_axi_arvalid, // AR valid
  input wire logic        s_axi_arready, // AR ready
  input wire logic        s_axi_rvalid,  // R valid
  input wire logic        s_axi_rready,  // R ready
  input wire logic [31:0] s_axi_rdata,   // R data
  input wire logic        s_axi_bvalid,  // B valid
  input wire logic        s_axi_bready,  // B ready
  input wire logic        lnk_req_q,     // Request
  input wire logic        lnk_done,      // Done
  input wire logic [31:0] lnk_out0_q,    // Word 0
  input wire logic        lnk_hw_order_q // Jumper
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  rd_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("second read taken");
  wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  req_pulse_a: assert property (lnk_req_q |=> !lnk_req_q)
    else $error("request longer than a cycle");
  req_gap_a: assert property (lnk_done |=> !lnk_req_q)
    else $error("request right after done");
  out_hold_a: assert property (!lnk_req_q |-> $stable(lnk_out0_q))
    else $error("outbound word moved");
  order_fixed_a: assert property (
    $past(aresetn) && $past(aresetn, 2) && $past(aresetn, 3) |-> $stable(lnk_hw_order_q))
    else $error("bit order changed while running");
endmodule
`default_nettype wire

/* File: testbench/rpd_link_model.sv */
// Remote I/O module on the far side of the link.
// Assumes requests are one-cycle pulses; lat of zero never answers.
`default_nettype none
module rpd_link_model (
  input wire logic        aclk,       // Clock
  input wire logic        lnk_req_q,  // Request
  input wire logic [95:0] out_w,      // Outbound words
  input wire logic [7:0]  lat,        // Answer delay
  input wire logic [7:0]  rf,         // Fault byte
  output var logic        lnk_done,   // Done pulse
  output var logic [95:0] in_w,       // Inbound words
  output logic     [23:0] lnk_status, // Status bytes
  output logic     [7:0]  lnk_rflt    // Remote faults
);
  timeunit 1ns;
  timeprecision 1ps;
  assign lnk_status = 24'h120300;
  assign lnk_rflt = rf;
  initial begin
    lnk_done = 1'b0;
    in_w = 96'h0;
    forever begin
      @(posedge aclk);
      if (lnk_req_q && lat != 8'h00) begin
        repeat (lat - 1) @(posedge aclk);
        lnk_done <= 1'b1;
        in_w <= ~out_w;
        @(posedge aclk);
        lnk_done <= 1'b0;
        // Payload is not held after done, so a late sample sees other data.
        in_w <= out_w;
      end
    end
  end
endmodule
`default_nettype wire

/* File: testbench/tb_remote_process_data_channel.sv */
// Bench for the channel bank with the link model and checker.
// Assumes the checker and model files are compiled first.
`default_nettype none
module tb_remote_process_data_channel;
  timeunit 1ns;
  timeprecision 1ps;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, pin, lf;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, d;
  logic [3:0]  ws;
  logic [1:0]  r;
  logic [7:0]  lat, rf, prs;
  logic [23:0] rows [13];
  wire  [31:0] o0, o1, o2, rdata;
  wire  [95:0] iw;
  wire  [23:0] st;
  wire  [7:0]  fl, md;
  wire  [2:0]  ch;
  wire  [1:0]  bresp, rresp;
  wire         awready, wready, arready, rvalid, bvalid, done, req, ho;
  int          bad_count, num_checks;
  rpd_channel_bank #(.XCHG_TIMEOUT_CYC(20'd20)) u_rpd_channel_bank (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(ws), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .bit_order_pin(pin), .lnk_present(prs),
    .lnk_done(done), .lnk_fail(lf), .lnk_in0(iw[31:0]), .lnk_in1(iw[63:32]),
    .lnk_in2(iw[95:64]), .lnk_status(st), .lnk_rflt(fl), .lnk_req_q(req), .lnk_chan_q(ch),
    .lnk_out0_q(o0), .lnk_out1_q(o1), .lnk_out2_q(o2), .lnk_mode_q(md), .lnk_hw_order_q(ho));
  rpd_link_model u_rpd_link_model (.aclk(aclk), .lnk_req_q(req), .out_w({o2, o1, o0}),
    .lat(lat), .rf(rf), .lnk_done(done), .in_w(iw), .lnk_status(st), .lnk_rflt(fl));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    {awvalid, wvalid, bready} <= 3'h7;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [11:0] a);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    rd(a);
    chk({30'h0, r}, 32'h0);
    chk(d, e);
  endtask
  task automatic idle;
    do rd(12'h000); while (d !== 32'h0);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, wdata} = '0;
    {ws, pin, lf, lat, rf, prs} = {4'hf, 1'b1, 1'b0, 8'h03, 8'h40, 8'h01};
    rows = '{24'h001020, 24'h001240, 24'h001800, 24'h0020a0, 24'h002130, 24'h002201,
      24'h002300, 24'h002a80, 24'h002b3f, 24'h003069, 24'h004380, 24'h006101, 24'h007201};
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk(12'h000, 32'h0);
    wr(12'h100, 32'h0);
    wr(12'h000, 32'h0903);
    idle();
    rchk(12'h004, 32'h02);
    rchk(12'h100, 32'h40120300);
    rchk(12'h10c, 32'h10);
    chk({31'h0, ho}, 32'h1);
    $display("start test done");
    foreach (rows[i]) begin
      wr(12'h00c, {16'h0, rows[i][23:8]});
      rchk(12'h010, {24'h0, rows[i][7:0]});
    end
    $display("descriptor test done");
    for (int i = 0; i < 3; i++) begin
      lat <= 8'(1 + 9 * i);
      rf <= 8'h80 >> (3 * i);
      for (int k = 1; k < 4; k++) wr(12'(256 + 4 * k), 32'hc0de0000 + 16 * k + i);
      wr(12'h000, 32'h1001);
      idle();
      rchk(12'h004, 32'h0);
      rchk(12'h100, {rf, 24'h120300});
      for (int k = 1; k < 4; k++) rchk(12'(256 + 4 * k), ~(32'hc0de0000 + 16 * k + i));
    end
    chk({21'h0, ch, md}, 32'h0);
    $display("exchange test done");
    {lat, lf} <= {8'h02, 1'b1};
    wr(12'h000, 32'h1001);
    idle();
    rchk(12'h004, 32'h01);
    lf <= 1'b0;
    lat <= 8'h00;
    wr(12'h000, 32'h1001);
    idle();
    rchk(12'h004, 32'h01);
    rd(12'h100);
    chk({31'h0, d[13]}, 32'h1);
    wr(12'h000, 32'h1002);
    idle();
    rchk(12'h004, 32'h02);
    rd(12'h0f0);
    chk({30'h0, r}, 32'h2);
    $display("fault test done");
    report_and_stop();
  end
  // The tests take a few hundred cycles; ten thousand means a hang.
  initial begin
    #100000;
    bad_count++;
    report_and_stop();
  end
endmodule
bind rpd_channel_bank rpd_chk u_rpd_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .lnk_req_q(lnk_req_q), .lnk_done(lnk_done),
  .lnk_out0_q(lnk_out0_q), .lnk_hw_order_q(lnk_hw_order_q));
`default_nettype wire
